// ---- awf_consts.svh ----
`ifndef AWF_CONSTS_SVH
`define AWF_CONSTS_SVH
// word layout
`define AWF_WORD_W      12
`define AWF_MSB_POS     11
// pipeline latency from sample to delay-line output, in converter clocks; the output word follows one clock later
`define AWF_LATENCY     11
// clamp codes for positive and negative overrange, two's complement
`define AWF_POS_FS      12'h7FF
`define AWF_NEG_FS      12'h800
// output reset values
`define AWF_WORD_RST    12'h000
`endif

// ---- awf_pkg.sv ----
package awf_pkg;
    // raw sample from the pipeline core, two's complement with overrange marks
    typedef struct packed {
        logic [11:0] code;
        logic        overPos;
        logic        overNeg;
    } awf_sample_type;

    // one formatted output word with its range flag
    typedef struct packed {
        logic [11:0] word;
        logic        outOfRange;
    } awf_word_type;

    // differential output bundle
    typedef struct packed {
        logic [11:0] wordTrue;
        logic [11:0] wordComp;
        logic        rangeTrue;
        logic        rangeComp;
    } awf_lvds_type;
endpackage : awf_pkg

// ---- awf_latency_line.sv ----
`timescale 1ns/1ps
`include "awf_consts.svh"
module awf_latency_line
    import awf_pkg::*;
(
    // clock and reset
    input  wire logic           convClk,
    input  wire logic           nrstConv,
    // sample stream
    input  awf_sample_type      sampleIn,
    output awf_sample_type      sampleOut
);
    // fixed-depth delay; the core's pipeline latency is modelled here
    awf_sample_type pipe_q [`AWF_LATENCY];

    always_ff @(posedge convClk or negedge nrstConv) begin
        if (!nrstConv) begin
            for (int i = 0; i < `AWF_LATENCY; i++) pipe_q[i] <= '0;
        end else begin
            pipe_q[0] <= sampleIn;
            for (int i = 1; i < `AWF_LATENCY; i++) pipe_q[i] <= pipe_q[i-1];
        end
    end

    assign sampleOut = pipe_q[`AWF_LATENCY-1];
endmodule : awf_latency_line

// ---- awf_output_formatter.sv ----
`timescale 1ns/1ps
`include "awf_consts.svh"
module awf_output_formatter
    import awf_pkg::*;
(
    // system clock domain
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    // static selects, pins from outside
    input  wire logic           formatSelect,
    input  wire logic           rate_halve_select,
    // converter clock domain and core samples
    input  wire logic           convClk,
    input  awf_sample_type      sampleIn,
    // differential outputs
    output logic [11:0]         wordTrueOut,
    output logic [11:0]         wordCompOut,
    output logic                word_msb_true_out,
    output logic                word_msb_comp_out,
    output logic                fwd_clock_true_out,
    output logic                fwd_clock_comp_out,
    output logic                range_flag_true_out,
    output logic                range_flag_comp_out,
    // status in system domain
    output logic                formatSyncOut
);
    // reset released into converter domain synchronously
    logic nrstConvA_q;
    logic nrstConv_q;
    always_ff @(posedge convClk or negedge nrst) begin
        if (!nrst) begin
            nrstConvA_q <= 1'b0;
            nrstConv_q  <= 1'b0;
        end else begin
            nrstConvA_q <= 1'b1;
            nrstConv_q  <= nrstConvA_q;
        end
    end

    // static select pins synchronised into converter domain
    logic fmtA_q, fmtB_q, rateA_q, rateB_q;
    always_ff @(posedge convClk or negedge nrstConv_q) begin
        if (!nrstConv_q) begin
            fmtA_q  <= 1'b0;
            fmtB_q  <= 1'b0;
            rateA_q <= 1'b0;
            rateB_q <= 1'b0;
        end else begin
            fmtA_q  <= formatSelect;
            fmtB_q  <= fmtA_q;
            rateA_q <= rate_halve_select;
            rateB_q <= rateA_q;
        end
    end

    // format select also synchronised to the system clock for status
    logic fmtSysA_q, fmtSys_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fmtSysA_q <= 1'b0;
            fmtSys_q  <= 1'b0;
        end else begin
            fmtSysA_q <= formatSelect;
            fmtSys_q  <= fmtSysA_q;
        end
    end
    assign formatSyncOut = fmtSys_q;

    // cycles since reset release, saturating at the pipeline depth; the delay line
    // comes out of reset full of zeros, so the latency check must wait until it
    // has been refilled with real samples
    logic [3:0] liveCnt_q;
    always_ff @(posedge convClk or negedge nrstConv_q) begin
        if (!nrstConv_q) begin
            liveCnt_q <= 4'h0;
        end else if (liveCnt_q != 4'(`AWF_LATENCY)) begin
            liveCnt_q <= liveCnt_q + 4'h1;
        end
    end

    // core pipeline latency
    awf_sample_type delayed;
    awf_latency_line uLatency (
        .convClk   (convClk),
        .nrstConv  (nrstConv_q),
        .sampleIn  (sampleIn),
        .sampleOut (delayed)
    );

    // update strobe: every cycle, or every other cycle in halved mode
    logic phase_q;
    wire  updateEn = rateB_q | phase_q;
    always_ff @(posedge convClk or negedge nrstConv_q) begin
        if (!nrstConv_q) phase_q <= 1'b0;
        else             phase_q <= rateB_q ? 1'b1 : ~phase_q;
    end

    wire         outOfRange = delayed.overPos | delayed.overNeg;
    wire  [11:0] clamped    = delayed.overPos ? `AWF_POS_FS :
                              delayed.overNeg ? `AWF_NEG_FS : delayed.code;

    function automatic logic [11:0] toOffset(input logic [11:0] c);
        toOffset = {~c[`AWF_MSB_POS], c[`AWF_MSB_POS-1:0]};
    endfunction : toOffset

    wire  [11:0] formatted  = fmtB_q ? toOffset(clamped) : clamped;

    // output register, updated on enabled edges only
    awf_word_type out_q;
    always_ff @(posedge convClk or negedge nrstConv_q) begin
        if (!nrstConv_q) begin
            out_q <= '{word: `AWF_WORD_RST, outOfRange: 1'b0};
        end else if (updateEn) begin
            out_q <= '{word: formatted, outOfRange: outOfRange};
        end
    end

    // forwarded clock toggles at the update rate so its rise follows each new word
    logic fwd_q;
    always_ff @(negedge convClk or negedge nrstConv_q) begin
        if (!nrstConv_q)   fwd_q <= 1'b0;
        else if (rateB_q)  fwd_q <= 1'b1;
        else               fwd_q <= ~phase_q;
    end
    // full rate: mirror the converter clock; rise falls mid-word
    assign fwd_clock_true_out = rateB_q ? ~convClk : fwd_q;
    assign fwd_clock_comp_out = ~fwd_clock_true_out;

    assign wordTrueOut         = out_q.word;
    assign wordCompOut         = ~out_q.word;
    assign word_msb_true_out   = out_q.word[`AWF_MSB_POS];
    assign word_msb_comp_out   = ~out_q.word[`AWF_MSB_POS];
    assign range_flag_true_out = out_q.outOfRange;
    assign range_flag_comp_out = ~out_q.outOfRange;

    chk_flag_pair: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        range_flag_true_out != range_flag_comp_out)
        else $error("range flag pair not complementary");

    chk_word_pair: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        wordCompOut == ~wordTrueOut)
        else $error("word pair not complementary");

    chk_pos_clamp: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        updateEn && delayed.overPos |=> range_flag_true_out &&
        wordTrueOut == ($past(fmtB_q) ? 12'hFFF : 12'h7FF))
        else $error("positive overrange clamp wrong");

    chk_msb_flip: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        updateEn && fmtB_q && !outOfRange |=>
        wordTrueOut == {~$past(delayed.code[11]), $past(delayed.code[10:0])})
        else $error("offset binary not msb flip");

    chk_twos_pass: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        updateEn && !fmtB_q && !outOfRange |=> wordTrueOut == $past(delayed.code))
        else $error("two's complement word altered");

    // halved rate holds word for a cycle
    chk_half_hold: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        !rateB_q && !updateEn |=> $stable(out_q))
        else $error("word changed off update cycle");

    // full rate takes every new word
    chk_full_rate: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        rateB_q |=> {wordTrueOut, range_flag_true_out} == $past({formatted, outOfRange}))
        else $error("full rate missed update");

    chk_latency: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        liveCnt_q == 4'(`AWF_LATENCY) |-> delayed == $past(sampleIn, 11))
        else $error("pipeline latency not eleven");

    // flag stays low for in-range words
    chk_flag_clear: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        updateEn && !outOfRange |=> !range_flag_true_out && range_flag_comp_out)
        else $error("range flag set for in-range word");

    // halved rate: forwarded clock is low at each update
    // so the receiver's latching rise always trails the new word
    chk_fwd_half: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        !rateB_q && updateEn |-> !fwd_clock_true_out)
        else $error("forwarded clock high at word update");

    chk_fwd_pair: assert property (@(negedge convClk) disable iff (!nrstConv_q)
        fwd_clock_comp_out != fwd_clock_true_out)
        else $error("forwarded clock pair not complementary");

    // msb pins carry bit 11 of the word as a pair
    chk_msb_pins: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        word_msb_true_out == wordTrueOut[`AWF_MSB_POS] &&
        word_msb_comp_out != word_msb_true_out)
        else $error("msb pin pair wrong");

    chk_or_flag: assert property (@(posedge convClk) disable iff (!nrstConv_q)
        updateEn && delayed.overNeg |=> range_flag_true_out &&
        wordTrueOut == ($past(fmtB_q) ? 12'h000 : 12'h800))
        else $error("negative overrange flag missing");
endmodule : awf_output_formatter

// ---- awf_capture_model.sv ----
`timescale 1ns/1ps
module awf_capture_model
    import awf_pkg::*;
(
    // forwarded clock and pins
    input  wire logic        dataClk,
    input  wire logic [11:0] word,
    input  wire logic        flag,
    // captured word
    output awf_word_type     capOut
);
    // latch on forwarded rise
    // no reset: a real receiver has none either
    always_ff @(posedge dataClk) begin
        capOut <= '{word: word, outOfRange: flag};
    end
endmodule : awf_capture_model

// ---- awf_output_formatter_tb.sv ----
`timescale 1ns/1ps
module awf_output_formatter_tb;
    import awf_pkg::*;
    // clocks, reset, selects and pins
    logic           ref_clk, nrst, convClk, formatSelect, rate_halve_select;
    awf_sample_type sampleIn;
    awf_sample_type hist[0:63];
    awf_word_type   capOut;
    logic [11:0]    wordTrueOut, wordCompOut;
    logic           msbT, msbC, fwdT, fwdC, flagT, flagC, fmtSync;
    int             error_cnt, total_checks;

    awf_output_formatter dut (.ref_clk(ref_clk), .nrst(nrst), .formatSelect(formatSelect),
        .rate_halve_select(rate_halve_select), .convClk(convClk), .sampleIn(sampleIn),
        .wordTrueOut(wordTrueOut), .wordCompOut(wordCompOut), .word_msb_true_out(msbT),
        .word_msb_comp_out(msbC), .fwd_clock_true_out(fwdT), .fwd_clock_comp_out(fwdC),
        .range_flag_true_out(flagT), .range_flag_comp_out(flagC), .formatSyncOut(fmtSync));
    awf_capture_model rx (.dataClk(fwdT), .word(wordTrueOut), .flag(flagT), .capOut(capOut));

    // two unrelated clocks, converter clock offset by 3 ns
    initial begin
        ref_clk = 0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        convClk = 0;
        #3;
        forever #16 convClk = ~convClk;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // clamp, then flip only the top bit for offset coding
    function automatic logic [12:0] expw(awf_sample_type s, logic f);
        logic [11:0] c;
        c = s.overPos ? 12'h7FF : (s.overNeg ? 12'h800 : s.code);
        return {c[11] ^ f, c[10:0], s.overPos | s.overNeg};
    endfunction : expw

    task end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // ramp with sparse overrange marks, checked against history
    task run(input logic f, input logic r, input int n);
        logic [12:0] e, e2, sel;
        logic [11:0] prev;
        int          chg;
        chg = 0;
        nrst = 0;
        formatSelect = f;
        rate_halve_select = r;
        sampleIn = '0;
        repeat (3) @(posedge convClk);
        #1;
        chk({wordTrueOut, flagT, flagC}, {12'h000, 2'b01});
        chk(wordCompOut, 12'hFFF);
        @(posedge ref_clk);
        #1 nrst = 1;
        for (int k = 0; k < n; k++) begin
            @(posedge convClk);
            #1;
            if (k >= 16) begin
                e = expw(hist[k-12], f);
                e2 = expw(hist[k-13], f);
                // halved rate: fresh word on odd iterations, held word on even ones
                sel = (r || k % 2 == 1) ? e : e2;
                chk({wordTrueOut, flagT}, sel);
                chk({wordCompOut, msbT, msbC, flagC, fwdC},
                    {~wordTrueOut, wordTrueOut[11], ~wordTrueOut[11], ~flagT, ~fwdT});
                if (r || k % 2 == 0) chk(capOut, e2);
                chg += (wordTrueOut !== prev);
            end
            prev = wordTrueOut;
            hist[k] = {12'(k * 37 + 5), k % 8 == 3, k % 8 == 6};
            sampleIn = hist[k];
        end
        chk(fmtSync, f);
        if (!r) chk(chg <= (n - 15) / 2, 1);
    endtask : run

    // main sequence: every format with both rates
    initial begin
        nrst = 0;
        formatSelect = 0;
        rate_halve_select = 1;
        sampleIn = '0;
        error_cnt = 0;
        total_checks = 0;
        run(0, 1, 40);
        run(1, 1, 40);
        run(0, 0, 40);
        run(1, 0, 40);
        end_of_test();
    end

    // hang guard
    initial begin
        #60000;
        error_cnt++;
        end_of_test();
    end
endmodule : awf_output_formatter_tb
